// file: common/hbp_pkg.sv
// Purpose: Shared constants and types for the host processor bus port.
// Assumes: One 100 MHz clock; every host pin arrives asynchronously.
// Notes:   Both design files import this package whole.

package hbp_pkg;

	// ****************************************************************
	// Widths and fixed encodings
	// ****************************************************************
	localparam int               HBP_DATA_W        = 16;
	localparam int               HBP_ADDR_W        = 19;
	localparam int               HBP_WORD_W        = 18;
	localparam int               HBP_CTRL_W        = 6;
	localparam logic [17:0]      HBP_VALID_WORDS   = 18'h20000;
	localparam logic             HBP_STYLE_STROBE  = 1'b0;
	localparam logic             HBP_STYLE_BYTE_EN = 1'b1;
	localparam logic             HBP_RW_WRITE      = 1'b0;
	localparam logic             HBP_RW_READ       = 1'b1;
	localparam logic [5:0]       HBP_CTRL_RST      = 6'h3F;
	localparam logic [34:0]      HBP_BUS_RST       = 35'h0;
	localparam logic [0:0]       HBP_DEVRST_RST    = 1'h0;
	localparam logic [15:0]      HBP_RDATA_RST     = 16'h0;

	// ****************************************************************
	// Types
	// ****************************************************************
	// One request toward the internal register and memory space.
	typedef struct packed {
		logic                    write;
		logic [HBP_WORD_W-1:0]   word_addr;
		logic [HBP_DATA_W-1:0]   wdata;
		logic [1:0]              lanes;
	} hbp_req_t;

	typedef enum logic [2:0] {
		HBP_ST_IDLE = 3'h1,
		HBP_ST_REQ  = 3'h2,
		HBP_ST_DONE = 3'h4
	} hbp_state_t;

endpackage : hbp_pkg

// file: design/hbp_sync.sv
// Purpose: Two-stage synchroniser for a group of asynchronous levels.
// Assumes: The group is a bundle of levels held stable by their source.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/10ps
`default_nettype none

module hbp_sync
	import hbp_pkg::*;
#(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic           ref_clk,
	input  wire logic           rst,
	input  wire logic [W-1:0]   d,
	output var  logic [W-1:0]   q
);

	logic [W-1:0] meta_q;

	// Two flip-flops in series; reset loads a constant idle level.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : hbp_sync

`default_nettype wire

// file: design/hbp_port.sv
// Purpose: Slave side of the 16-bit non-multiplexed host processor port.
// Assumes: Host pins are asynchronous; the core answers each request.
// Notes:   Open-drain style outputs come as value plus output enable.
//
// Function
// - Access only while chip select and strobe low.
// - Read/write low writes, high reads.
// - Acknowledge low when done, else released.
// - Bus fault low on invalid address.
// - Strobe style: fault suppresses the acknowledge.
// - Byte-enable style: acknowledge despite any fault.
// - Wait low until data is ready, else released.
// - Strobe style: lane inputs are lane strobes.
// - Byte-enable style: lane inputs are byte enables.
// - Bus style select: low strobes, high enables.
// - Reset pin low holds the port reset.
// - Sixteen-bit data bus, driven on reads only.
// - Nineteen-bit address, lowest bit ignored.
`timescale 1ns/10ps
`default_nettype none

module hbp_port
	import hbp_pkg::*;
#(
	parameter logic [HBP_WORD_W-1:0] VALID_WORDS = HBP_VALID_WORDS
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   device_reset_n,
	input  wire logic                   chip_select_n,
	input  wire logic                   data_strobe_n,
	input  wire logic                   read_write,
	input  wire logic [1:0]             lane_select,
	input  wire logic                   bus_style_select,
	input  wire logic [HBP_ADDR_W-1:0]  host_address_bus,
	input  wire logic [HBP_DATA_W-1:0]  host_data_in,
	output var  logic [HBP_DATA_W-1:0]  host_data_out,
	output var  logic                   host_data_oe,
	output var  logic                   transfer_ack_n,
	output var  logic                   transfer_ack_oe,
	output var  logic                   wait_n,
	output var  logic                   wait_oe,
	output var  logic                   bus_fault_n,
	output var  logic                   bus_fault_oe,
	output var  logic                   core_req_valid,
	output var  hbp_req_t               core_req,
	input  wire logic                   core_ack,
	input  wire logic [HBP_DATA_W-1:0]  core_rdata
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [HBP_CTRL_W-1:0]  ctrl_s;
	logic [34:0]            bus_s;
	logic                   dev_rst_n_s;
	logic                   cs_n_s;
	logic                   ds_n_s;
	logic                   rw_s;
	logic [1:0]             lane_n_s;
	logic                   style_s;
	logic                   sel_s;
	logic                   rst_int;
	logic                   addr_bad;
	logic [HBP_WORD_W-1:0]  word_s;
	logic [HBP_DATA_W-1:0]  wdata_s;

	hbp_sync #(.W(HBP_CTRL_W), .RST_VAL(HBP_CTRL_RST)) u_ctrl_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       ({chip_select_n, data_strobe_n, read_write,
		           lane_select, bus_style_select}),
		.q       (ctrl_s)
	);

	// Address bit zero is not synchronised at all: it is never used.
	hbp_sync #(.W(35), .RST_VAL(HBP_BUS_RST)) u_bus_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       ({host_address_bus[HBP_ADDR_W-1:1], host_data_in,
		           1'b0}),
		.q       (bus_s)
	);

	// The reset pin is asynchronous to ref_clk, so it is synchronised
	// like any other level and then ORed with rst into the internal reset.
	hbp_sync #(.W(1), .RST_VAL(HBP_DEVRST_RST)) u_rst_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       (device_reset_n),
		.q       (dev_rst_n_s)
	);

	assign cs_n_s   = ctrl_s[5];
	assign ds_n_s   = ctrl_s[4];
	assign rw_s     = ctrl_s[3];
	assign lane_n_s = ctrl_s[2:1];
	assign style_s  = ctrl_s[0];
	assign word_s   = bus_s[34:17];
	assign wdata_s  = bus_s[16:1];

	// Reset pin low keeps the whole port idle with every pin released.
	assign rst_int  = rst | ~dev_rst_n_s;

	// An access exists only while both active-low selects are low.
	assign sel_s    = ~cs_n_s & ~ds_n_s;

	// Words at or above the limit are not part of the internal space.
	assign addr_bad = (word_s >= VALID_WORDS);

	// ****************************************************************
	// Access sequencer
	// ****************************************************************
	hbp_state_t  st_q;
	logic        style_q;
	logic        fault_q;

	// The host keeps the access stable until it sees the acknowledge,
	// so a strobe release is the only event that ends an access.
	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			st_q <= HBP_ST_IDLE;
		end else begin
			case (st_q)
			HBP_ST_IDLE: begin
				if (sel_s && addr_bad) begin
					st_q <= HBP_ST_DONE;
				end else if (sel_s) begin
					st_q <= HBP_ST_REQ;
				end
			end
			HBP_ST_REQ: begin
				if (core_ack) begin
					st_q <= HBP_ST_DONE;
				end
			end
			HBP_ST_DONE: begin
				if (!sel_s) begin
					st_q <= HBP_ST_IDLE;
				end
			end
			default: begin
				st_q <= HBP_ST_IDLE;
			end
			endcase
		end
	end

	// Bus style and fault status are frozen for the whole access.
	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			style_q <= HBP_STYLE_STROBE;
			fault_q <= 1'b0;
		end else if (st_q == HBP_ST_IDLE && sel_s) begin
			style_q <= style_s;
			fault_q <= addr_bad;
		end
	end

	// Request toward the core; the lane inputs are active-low in both
	// styles, so one inversion serves strobes and byte enables alike.
	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			core_req <= '0;
		end else if (st_q == HBP_ST_IDLE && sel_s) begin
			core_req.write     <= (rw_s == HBP_RW_WRITE);
			core_req.word_addr <= word_s;
			core_req.wdata     <= wdata_s;
			core_req.lanes     <= ~lane_n_s;
		end
	end

	// Handshake toward the core is taken straight from the state.
	assign core_req_valid = (st_q == HBP_ST_REQ);

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	// Low values are constant; only the enables carry the signalling.
	assign transfer_ack_n = 1'b0;
	assign wait_n         = 1'b0;
	assign bus_fault_n    = 1'b0;

	// Wait is held from the start of a valid access until the core
	// answers; a faulted access never waits.
	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			wait_oe <= 1'b0;
		end else if (st_q == HBP_ST_IDLE) begin
			wait_oe <= sel_s & ~addr_bad;
		end else if (st_q == HBP_ST_REQ && core_ack) begin
			wait_oe <= 1'b0;
		end
	end

	// Acknowledge and fault enables stand until the strobes release.
	// A fault in strobe style withholds the acknowledge; in byte
	// enable style the acknowledge comes anyway.
	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			transfer_ack_oe <= 1'b0;
			bus_fault_oe    <= 1'b0;
		end else begin
			case (st_q)
			HBP_ST_IDLE: begin
				bus_fault_oe    <= sel_s & addr_bad;
				transfer_ack_oe <= sel_s & addr_bad &
				                   (style_s == HBP_STYLE_BYTE_EN);
			end
			HBP_ST_REQ: begin
				transfer_ack_oe <= core_ack;
				bus_fault_oe    <= 1'b0;
			end
			HBP_ST_DONE: begin
				if (!sel_s) begin
					transfer_ack_oe <= 1'b0;
					bus_fault_oe    <= 1'b0;
				end
			end
			default: begin
				transfer_ack_oe <= 1'b0;
				bus_fault_oe    <= 1'b0;
			end
			endcase
		end
	end

	// Read data is registered with the acknowledge; the bus is only
	// driven for a read, so a write never fights the host.
	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			host_data_out <= HBP_RDATA_RST;
			host_data_oe  <= 1'b0;
		end else if (st_q == HBP_ST_REQ && core_ack) begin
			host_data_out <= core_rdata;
			host_data_oe  <= ~core_req.write;
		end else if (st_q == HBP_ST_DONE && !sel_s) begin
			host_data_oe  <= 1'b0;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_start;
		st_q == HBP_ST_IDLE && sel_s && !addr_bad && !rst_int;
	endsequence

	sequence s_bad_start;
		st_q == HBP_ST_IDLE && sel_s && addr_bad && !rst_int;
	endsequence

	property p_ack_needs_select;
		transfer_ack_oe |-> $past(sel_s);
	endproperty
	a_ack_needs_select: assert property (p_ack_needs_select)
		else $error("Acknowledge driven without a selected access.");

	property p_write_type;
		s_start |=> core_req_valid &&
		            core_req.write == ($past(rw_s) == HBP_RW_WRITE);
	endproperty
	a_write_type: assert property (p_write_type)
		else $error("Request type does not follow read/write.");

	property p_ack_after_core;
		(core_req_valid && core_ack && !rst_int) |=>
			transfer_ack_oe && !wait_oe;
	endproperty
	a_ack_after_core: assert property (p_ack_after_core)
		else $error("Acknowledge missing after core answer.");

	property p_fault_flag;
		s_bad_start |=> bus_fault_oe && !core_req_valid;
	endproperty
	a_fault_flag: assert property (p_fault_flag)
		else $error("Invalid address did not raise bus fault.");

	property p_fault_no_ack;
		(bus_fault_oe && style_q == HBP_STYLE_STROBE) |-> !transfer_ack_oe;
	endproperty
	a_fault_no_ack: assert property (p_fault_no_ack)
		else $error("Acknowledge given with fault in strobe style.");

	property p_fault_with_ack;
		(bus_fault_oe && style_q == HBP_STYLE_BYTE_EN) |-> transfer_ack_oe;
	endproperty
	a_fault_with_ack: assert property (p_fault_with_ack)
		else $error("Acknowledge missing with fault in enable style.");

	property p_wait_while_req;
		s_start |=> wait_oe throughout (core_req_valid [*1]);
	endproperty
	a_wait_while_req: assert property (p_wait_while_req)
		else $error("Wait not shown while request pending.");

	property p_lanes;
		s_start |=> core_req.lanes == ~$past(lane_n_s);
	endproperty
	a_lanes: assert property (p_lanes)
		else $error("Lane enables do not follow lane inputs.");

	property p_reset_pin;
		!dev_rst_n_s |=> st_q == HBP_ST_IDLE && !wait_oe &&
		                 !transfer_ack_oe && !host_data_oe;
	endproperty
	a_reset_pin: assert property (p_reset_pin)
		else $error("Port not idle while reset pin low.");

	property p_drive_on_read;
		host_data_oe |-> !core_req.write && transfer_ack_oe;
	endproperty
	a_drive_on_read: assert property (p_drive_on_read)
		else $error("Data bus driven outside a read acknowledge.");

endmodule : hbp_port

`default_nettype wire

// file: testbench/hbp_host_model.sv
// Purpose: Host bus master model for the host processor bus port.
// Assumes: Pins are driven and sampled on the rising edge of ref_clk.
// Notes:   Requests are held until an answer shows on the pulled-up pins.
`timescale 1ns/10ps
`default_nettype none

module hbp_host_model
	import hbp_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  ack_pin,
	input  wire logic                  fault_pin,
	output var  logic                  chip_select_n,
	output var  logic                  data_strobe_n,
	output var  logic                  read_write,
	output var  logic [1:0]            lane_select,
	output var  logic                  bus_style_select,
	output var  logic [HBP_ADDR_W-1:0] host_address_bus,
	output var  logic [HBP_DATA_W-1:0] host_data_in
);
	// Idle host: selects released, bus at a defined level.
	initial begin
		chip_select_n = 1'b1;
		data_strobe_n = 1'b1;
		read_write = HBP_RW_READ;
		lane_select = 2'h3;
		bus_style_select = HBP_STYLE_STROBE;
		host_address_bus = 19'h0;
		host_data_in = 16'h0;
	end

	// One access; ok is cleared if no answer or no release is seen.
	task automatic access(input logic style, input logic rw,
		input logic [1:0] lanes_n, input logic [HBP_ADDR_W-1:0] addr,
		input logic [HBP_DATA_W-1:0] wdata, output bit ok);
		int n;
		ok = 1'b0;
		@(posedge ref_clk);
		bus_style_select <= style;
		read_write <= rw;
		lane_select <= lanes_n;
		host_address_bus <= addr;
		// A read leaves the bus to the device, so show a moving pattern.
		host_data_in <= (rw == HBP_RW_WRITE) ? wdata : ~host_data_in;
		chip_select_n <= 1'b0;
		data_strobe_n <= 1'b0;
		for (n = 0; n < 100 && !ok; n++) begin
			@(posedge ref_clk);
			ok = !ack_pin || !fault_pin;
		end
		chip_select_n <= 1'b1;
		data_strobe_n <= 1'b1;
		host_data_in <= ~host_data_in;
		for (n = 0; n < 100 && !(ack_pin && fault_pin); n++)
			@(posedge ref_clk);
		ok = ok && ack_pin && fault_pin;
	endtask : access
endmodule : hbp_host_model
`default_nettype wire

// file: testbench/test_host_processor_bus_port.sv
// Purpose: Self-checking bench for the host processor bus port.
// Assumes: Core answers after a random delay; pins have pull-ups.
// Notes:   Notes queued by the drivers are matched by one monitor.
`timescale 1ns/10ps
`default_nettype none

module test_host_processor_bus_port
	import hbp_pkg::*;
;
	logic ref_clk, rst, device_reset_n, cs_n, ds_n, rw, style;
	logic [1:0] lanes;
	logic [18:0] addr;
	logic [15:0] mdata, din, dout, core_rdata;
	logic doe, ack_n, ack_oe, wt_n, wt_oe, flt_n, flt_oe;
	logic vld, core_ack, ack_pin, wt_pin, flt_pin, req_seen, ans_seen;
	hbp_req_t req, req_x;
	hbp_req_t req_q[$];
	logic [2:0] out_q[$];
	logic [15:0] rd_q[$];
	logic [1:0] dly;
	logic [31:0] seed, r;
	int miscompares, checks, i;
	bit ok, bad;

	// Pull-ups hold each released pin high.
	assign ack_pin = ack_oe ? ack_n : 1'b1;
	assign wt_pin = wt_oe ? wt_n : 1'b1;
	assign flt_pin = flt_oe ? flt_n : 1'b1;
	assign din = doe ? dout : mdata;

	always #5 ref_clk = ~ref_clk;

	hbp_port dut_u (.ref_clk(ref_clk), .rst(rst),
		.device_reset_n(device_reset_n), .chip_select_n(cs_n),
		.data_strobe_n(ds_n), .read_write(rw), .lane_select(lanes),
		.bus_style_select(style), .host_address_bus(addr),
		.host_data_in(din), .host_data_out(dout), .host_data_oe(doe),
		.transfer_ack_n(ack_n), .transfer_ack_oe(ack_oe), .wait_n(wt_n),
		.wait_oe(wt_oe), .bus_fault_n(flt_n), .bus_fault_oe(flt_oe),
		.core_req_valid(vld), .core_req(req), .core_ack(core_ack),
		.core_rdata(core_rdata));

	hbp_host_model host_u (.ref_clk(ref_clk), .ack_pin(ack_pin),
		.fault_pin(flt_pin), .chip_select_n(cs_n), .data_strobe_n(ds_n),
		.read_write(rw), .lane_select(lanes), .bus_style_select(style),
		.host_address_bus(addr), .host_data_in(mdata));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	// Core model: answers after 0 to 3 cycles and notes read data.
	always @(posedge ref_clk) begin
		if (core_ack) begin
			core_ack <= 1'b0;
		end else if (vld && dly == 2'd0) begin
			r = rnd();
			core_ack <= 1'b1;
			core_rdata <= r[15:0];
			if (!req.write)
				rd_q.push_back(r[15:0]);
			dly <= r[17:16];
		end else if (vld) begin
			dly <= dly - 2'd1;
		end
	end

	// Monitor: takes the oldest note whenever a request or a result appears.
	always @(posedge ref_clk) begin
		if (vld && !req_seen && req_q.size() > 0) begin
			req_x = req_q.pop_front();
			check(req.write, req_x.write);
			check(req.word_addr, req_x.word_addr);
			check(req.lanes, req_x.lanes);
			if (req_x.write)
				check(req.wdata, req_x.wdata);
		end
		if (vld)
			check(wt_pin, 1'b0);
		if ((!ack_pin || !flt_pin) && !ans_seen && out_q.size() > 0) begin
			check({flt_pin, ack_pin, doe}, out_q.pop_front());
			check(wt_pin, 1'b1);
			if (doe && rd_q.size() > 0)
				check(dout, rd_q.pop_front());
		end
		req_seen = vld;
		ans_seen = !ack_pin || !flt_pin;
	end

	// Notes the expected outcome, then runs one host access.
	task automatic go(input logic s, input logic w, input logic [1:0] l,
		input logic [18:0] a, input logic [15:0] d);
		if (!bad)
			req_q.push_back('{~w, a[18:1], d, ~l});
		out_q.push_back({!bad, bad && s == HBP_STYLE_STROBE,
			w == HBP_RW_READ && !bad});
		host_u.access(s, w, l, a, d, ok);
		if (!ok) begin
			miscompares++;
			$display("[FAIL] %0t access never finished", $time);
			finish_test;
		end
	endtask : go

	// Main sequence: every lane code in both styles, bad addresses,
	// and a device reset pulse in mid-run.
	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		device_reset_n = 1'b1;
		core_ack = 1'b0;
		core_rdata = 16'h0;
		dly = 2'h0;
		seed = 32'h240D1018;
		miscompares = 0;
		checks = 0;
		req_seen = 1'b0;
		ans_seen = 1'b0;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (5) @(posedge ref_clk);
		for (i = 0; i < 40; i++) begin
			r = rnd();
			bad = (i % 5 == 4);
			go(i[2], bad ? HBP_RW_WRITE : r[1], i[1:0],
				{bad, r[22:5]}, r[31:16]);
			if (i == 20) begin
				device_reset_n <= 1'b0;
				repeat (4) @(posedge ref_clk);
				check({ack_oe, wt_oe, flt_oe, doe, vld}, 5'h0);
				device_reset_n <= 1'b1;
				repeat (4) @(posedge ref_clk);
			end
		end
		finish_test;
	end
endmodule : test_host_processor_bus_port
`default_nettype wire
